// File: bench/clock_output_config_assertions.sv
/*
 Checker for the clock output block; shadows serial writes from the pins.
 Assumes bind to the top module.
*/
`timescale 1ns/100ps

module clock_output_config_assertions (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic reg_clk_i,
    input wire logic reg_data_i,
    input wire logic reg_latch_i,
    input wire logic sync_pin_i,
    input wire logic [11:0] main_clock_output_p_o,
    input wire logic [11:0] main_clock_output_n_o,
    input wire logic ref_buffer_a_p_o,
    input wire logic ref_buffer_a_n_o,
    input wire logic ref_buffer_b_p_o,
    input wire logic ref_buffer_b_n_o,
    input wire logic [1:0] ref_buffer_b_amplitude_o,
    input wire logic sync_active_o
);
    // Shadow runs ahead of the design, so checks wait until writes settle
    logic [31:0] sh_q, ref_q, syn_q;
    logic [2:0][31:0] fmt_q;
    logic ck_q, lt_q, act, ok;
    logic [4:0] quiet_q;
    assign act = sync_pin_i ^ syn_q[16];
    assign ok = quiet_q > 5'h05;
    always_ff @(posedge clock_i)
    begin
        ck_q <= reg_clk_i;
        lt_q <= reg_latch_i;
        if (reg_clk_i && !ck_q)
            sh_q <= {sh_q[30:0], reg_data_i};
        if (rst_i || reg_latch_i)
            quiet_q <= 5'h00;
        else if (quiet_q != 5'h1F)
            quiet_q <= quiet_q + 5'h01;
        if (rst_i)
        begin
            ref_q <= 32'h0;
            syn_q <= 32'h0;
            fmt_q <= '0;
        end
        else if (reg_latch_i && !lt_q)
        begin
            if (sh_q[4:0] inside {5'h06, 5'h07, 5'h08})
                fmt_q[sh_q[1:0] - 2'h2] <= sh_q;
            if (sh_q[4:0] == 5'h0A)
                ref_q <= sh_q;
            if (sh_q[4:0] == 5'h0B)
                syn_q <= sh_q;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence s_held;
        sync_active_o [*2];
    endsequence
    property p_pin_sync;
        ok && act |=> sync_active_o;
    endproperty
    a_pin_sync: assert property (p_pin_sync) else $error("pin sync missed");
    property p_sync_idle;
        quiet_q == 5'h1F && !act |=> !sync_active_o;
    endproperty
    a_sync_idle: assert property (p_sync_idle) else $error("sync without cause");
    property p_held_low;
        s_held ##0 (ok && !syn_q[20] && fmt_q[0][19:16] == 4'h1) |->
            !main_clock_output_p_o[0] && main_clock_output_n_o[0];
    endproperty
    a_held_low: assert property (p_held_low) else $error("group not held low");
    property p_amp;
        ok |-> ref_buffer_b_amplitude_o == ref_q[31:30];
    endproperty
    a_amp: assert property (p_amp) else $error("amplitude wrong");
    property p_ref_a_off;
        ok && (!ref_q[22] || ref_q[27:24] == 4'h0) |-> !ref_buffer_a_p_o && !ref_buffer_a_n_o;
    endproperty
    a_ref_a_off: assert property (p_ref_a_off) else $error("buffer a driven");
    property p_ref_b_off;
        ok && !ref_q[23] |-> !ref_buffer_b_p_o && !ref_buffer_b_n_o;
    endproperty
    a_ref_b_off: assert property (p_ref_b_off) else $error("buffer b driven");
    property p_ref_b_comp;
        ok && ref_q[23] |-> ref_buffer_b_p_o != ref_buffer_b_n_o;
    endproperty
    a_ref_b_comp: assert property (p_ref_b_comp) else $error("buffer b not differential");
    for (genvar g = 0; g < 12; g++)
    begin : per_out
        logic [3:0] f;
        assign f = fmt_q[g / 4][16 + 4 * (g % 4) +: 4];
        property p_dark;
            ok && f inside {4'h0, 4'hE, 4'hF} |-> !main_clock_output_p_o[g] && !main_clock_output_n_o[g];
        endproperty
        a_dark: assert property (p_dark) else $error("dark output driven");
        property p_comp;
            ok && f inside {[4'h1:4'h7]} |-> main_clock_output_p_o[g] != main_clock_output_n_o[g];
        endproperty
        a_comp: assert property (p_comp) else $error("pair not complementary");
    end
endmodule

// File: bench/clock_output_config_bench.sv
/*
 Self-checking bench for the clock output block.
 Assumes the host model and bound checker; reference runs at quarter rate.
*/
`timescale 1ns/100ps
`include "clock_output_cfg.svh"

module clock_output_config_bench;
    logic clock_i, rst_i, reg_clk_i, reg_data_i, reg_latch_i, vco_tick_i, reference_input_i, sync_pin_i;
    logic [11:0] main_clock_output_p_o, main_clock_output_n_o;
    logic ref_buffer_a_p_o, ref_buffer_a_n_o, ref_buffer_b_p_o, ref_buffer_b_n_o, sync_active_o;
    logic [1:0] ref_buffer_b_amplitude_o;
    logic [5:0] group_extended_mode_o;
    logic [1:0] phase_q = 2'h0;
    int ratio[9] = '{8, 2, 2, 3, 4, 5, 6, 7, 1};
    int n_mismatch = 0;
    int total_checks = 0;
    int tog0, tog10, per;
    clock_output_config i_clock_output_config (.clock_i, .rst_i, .reg_clk_i, .reg_data_i, .reg_latch_i,
        .vco_tick_i, .reference_input_i, .sync_pin_i, .main_clock_output_p_o, .main_clock_output_n_o,
        .ref_buffer_a_p_o, .ref_buffer_a_n_o, .ref_buffer_b_p_o, .ref_buffer_b_n_o,
        .ref_buffer_b_amplitude_o, .group_extended_mode_o, .sync_active_o);
    serial_host_model i_serial_host_model (.clock_i, .reg_clk_o(reg_clk_i), .reg_data_o(reg_data_i),
        .reg_latch_o(reg_latch_i));
    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    always @(negedge clock_i)
        phase_q <= phase_q + 2'h1;
    assign reference_input_i = phase_q[1];
    assign vco_tick_i = phase_q[0];
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        i_serial_host_model.send(a, d);
        repeat (4) @(negedge clock_i);
    endtask
    // Cycles from one rise of buffer a to the next
    task automatic period_of();
        int t;
        t = 0;
        per = 0;
        for (int k = 0; k < 4; k++)
            while (ref_buffer_a_p_o !== k[0] && t < 400)
            begin
                @(negedge clock_i);
                t++;
                per += k > 1;
            end
    endtask
    task automatic watch(input int cycles);
        logic p0, p10;
        tog0 = 0;
        tog10 = 0;
        per = 0;
        repeat (cycles)
        begin
            p0 = main_clock_output_p_o[0];
            p10 = main_clock_output_p_o[10];
            @(negedge clock_i);
            tog0 += main_clock_output_p_o[0] !== p0;
            tog10 += main_clock_output_p_o[10] !== p10;
            per += sync_active_o === 1'b1;
        end
    endtask
    task automatic close_out();
        $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clock_i);
        n_mismatch++;
        close_out();
    end
    initial
    begin
        rst_i = 1'b1;
        sync_pin_i = 1'b0;
        repeat (5) @(negedge clock_i);
        rst_i = 1'b0;
        check("amplitude", 32'h0, ref_buffer_b_amplitude_o);
        check("extended", 32'h0, group_extended_mode_o);
        $display("Test reset done");
        for (int c = 3; c >= 0; c--)
        begin
            wr(5'h0A, {c[1:0], 30'h0080_0000});
            check("amplitude", c, ref_buffer_b_amplitude_o);
        end
        wr(5'h0C, 32'hC000_0000);
        i_serial_host_model.write_fixed();
        repeat (4) @(negedge clock_i);
        check("amplitude", 32'h0, ref_buffer_b_amplitude_o);
        $display("Test amplitude done");
        for (int c = 0; c < 9; c++)
        begin
            wr(5'h0A, c < 8 ? 32'h0650_0000 | (c << 16) : 32'h0640_0000);
            period_of();
            period_of();
            check("ref period", 4 * ratio[c], per);
        end
        wr(5'h0A, 32'h0610_0000);
        check("buffer a", 32'h0, {ref_buffer_a_p_o, ref_buffer_a_n_o});
        wr(5'h0A, 32'h0050_0000);
        check("buffer a", 32'h0, {ref_buffer_a_p_o, ref_buffer_a_n_o});
        $display("Test reference buffers done");
        wr(5'h00, 32'h0000_0340);
        wr(5'h01, 32'h0000_0320);
        wr(5'h05, 32'h0000_0040);
        check("extended", 32'h01, group_extended_mode_o);
        wr(5'h06, 32'h0001_0000);
        wr(5'h08, 32'h0600_0000);
        wr(5'h0B, 32'h0200_0000);
        sync_pin_i = 1'b1;
        repeat (2) @(negedge clock_i);
        watch(40);
        check("sync cycles", 40, per);
        check("group 0 toggles", 0, tog0);
        check("group 5 runs", 1, tog10 != 0);
        sync_pin_i = 1'b0;
        repeat (2) @(negedge clock_i);
        check("sync_active", 0, sync_active_o);
        wr(5'h0B, 32'h0201_0000);
        check("sync_active", 1, sync_active_o);
        sync_pin_i = 1'b1;
        repeat (2) @(negedge clock_i);
        check("sync_active", 0, sync_active_o);
        $display("Test pin sync done");
        i_serial_host_model.feedback_write(32'h0201_0000, 32'h0000_0600);
        watch(40);
        check("auto sync cycles", `AUTO_SYNC_CYCLES, per);
        $display("Test auto sync done");
        close_out();
    end
endmodule

bind clock_output_config clock_output_config_assertions i_clock_output_config_assertions (.clock_i, .rst_i,
    .reg_clk_i, .reg_data_i, .reg_latch_i, .sync_pin_i, .main_clock_output_p_o, .main_clock_output_n_o,
    .ref_buffer_a_p_o, .ref_buffer_a_n_o, .ref_buffer_b_p_o, .ref_buffer_b_n_o, .ref_buffer_b_amplitude_o,
    .sync_active_o);

// File: bench/serial_host_model.sv
/*
 Host on the serial register link; pins change on falling clock edges.
 Assumes the block samples on rising edges.
*/
`timescale 1ns/100ps

module serial_host_model (
    input wire logic clock_i,
    output logic reg_clk_o,
    output logic reg_data_o,
    output logic reg_latch_o
);
    // Value is arbitrary
    localparam logic [31:0] REG_NINE_WORD = 32'hC000_0000;
    initial
    begin
        reg_clk_o = 1'b0;
        reg_data_o = 1'b1;
        reg_latch_o = 1'b0;
    end
    // Clock idles low between frames; data idles at the inverse of its last bit
    task automatic send(input logic [4:0] a, input logic [31:0] d);
        for (int i = 31; i >= 0; i--)
        begin
            @(negedge clock_i);
            reg_clk_o = 1'b0;
            reg_data_o = i > 4 ? d[i] : a[i];
            @(negedge clock_i);
            reg_clk_o = 1'b1;
        end
        @(negedge clock_i);
        reg_clk_o = 1'b0;
        reg_data_o = ~a[0];
        reg_latch_o = 1'b1;
        @(negedge clock_i);
        reg_latch_o = 1'b0;
    endtask
    task automatic write_fixed();
        send(5'h09, REG_NINE_WORD);
    endtask
    // Exclusions cleared first so the automatic sync reaches every group
    task automatic feedback_write(input logic [31:0] sync_word, input logic [31:0] div_word);
        send(5'h0B, sync_word & 32'hFC0F_FFFF);
        send(5'h1E, div_word);
    endtask
endmodule

// File: hw/clock_output_cfg.svh
/*
 Register offsets, field positions, reset values and timing counts for the
 clock output configuration block.
 Assumes inclusion by bare name from the package and design modules.
*/
// What this block does
// - Feedback divider write raises sync automatically
// - Twelve 4-bit output formats in three registers
// - Format codes: off, LVDS, LVPECL, LVCMOS pairs
// - Buffer B is LVPECL, 2-bit amplitude field
// - Buffer A on needs format and enable
// - Each reference buffer has enable bit
// - Select bit: bypass or divided reference
// - Divider code 0 is 8, 1-2 are 2
// - Divide by one only via bypass
// - Six exclusion bits keep groups from syncing
// - Participating outputs held low during sync
// - Excluded groups keep toggling during sync
// - Exclusion leaves earlier alignment untouched
// - Polarity bit sets sync pin active level
// - Asserted sync pin holds participating outputs low
// - Group divider 26 or more means extended
`ifndef CLOCK_OUTPUT_CFG_SVH
`define CLOCK_OUTPUT_CFG_SVH

`define ADDR_GROUP_LAST 5'h05
`define ADDR_FORMAT_A 5'h06
`define ADDR_FORMAT_B 5'h07
`define ADDR_FORMAT_C 5'h08
`define ADDR_REF_CTRL 5'h0A
`define ADDR_SYNC_CTRL 5'h0B
`define ADDR_FEEDBACK_DIV 5'h1E

`define FMT_LSB 16
`define GROUP_DIV_LSB 5
`define GROUP_DIV_MSB 15
`define EXT_MODE_MIN 11'h01A
`define REF_B_AMP_MSB 31
`define REF_B_AMP_LSB 30
`define REF_A_FMT_MSB 27
`define REF_A_FMT_LSB 24
`define REF_B_EN_BIT 23
`define REF_A_EN_BIT 22
`define REF_B_SEL_BIT 21
`define REF_A_SEL_BIT 20
`define REF_DIV_MSB 18
`define REF_DIV_LSB 16
`define SYNC_EXCL_LSB 20
`define SYNC_POL_BIT 16

`define REG_RESET 32'h0000_0000
`define GROUP_DIV_RESET 11'h001

`define CLOCK_PERIOD_NS 10
`define AUTO_SYNC_NS 160
`define AUTO_SYNC_CYCLES ((`AUTO_SYNC_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// File: hw/clock_output_config.sv
/*
 Output side configuration of a multi-output clock generator: format of
 twelve main outputs, two reference buffers with divider, group sync.
 Assumes vco_tick_i is a one-cycle enable per VCO-derived period and all
 pins are synchronous to clock_i. Group clocks are modelled as levels.
*/
`timescale 1ns/100ps
`include "clock_output_cfg.svh"

module clock_output_config (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic reg_clk_i,
    input wire logic reg_data_i,
    input wire logic reg_latch_i,
    input wire logic vco_tick_i,
    input wire logic reference_input_i,
    input wire logic sync_pin_i,
    output logic [11:0] main_clock_output_p_o,
    output logic [11:0] main_clock_output_n_o,
    output logic ref_buffer_a_p_o,
    output logic ref_buffer_a_n_o,
    output logic ref_buffer_b_p_o,
    output logic ref_buffer_b_n_o,
    output logic [1:0] ref_buffer_b_amplitude_o,
    output logic [5:0] group_extended_mode_o,
    output logic sync_active_o
);
    reg_write_if wr_bus ();
    clock_output_pkg::top_state_t s_q, s_d;
    logic ref_div;
    logic ref_edge;
    logic pin_sync;
    logic sync_now;
    logic part;
    logic level;
    logic ref_a_src;
    logic ref_b_src;
    logic [10:0] div_eff;
    logic [1:0] pins;
    logic [3:0] fmt;
    logic [31:0] bank;

    serial_reg_port port_u (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .reg_clk_i(reg_clk_i),
        .reg_data_i(reg_data_i),
        .reg_latch_i(reg_latch_i),
        .wr_o(wr_bus.source)
    );

    ref_output_divider div_u (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ref_edge_i(ref_edge),
        .code_i(s_q.ref_ctrl[`REF_DIV_MSB:`REF_DIV_LSB]),
        .div_o(ref_div)
    );

    assign ref_edge = reference_input_i & ~s_q.ref_prev;

    always_comb
    begin
        s_d = s_q;
        s_d.ref_prev = reference_input_i;
        div_eff = 11'h001;
        part = 1'b0;
        level = 1'b0;
        pins = 2'h0;
        fmt = 4'h0;
        bank = '0;
        if (s_q.auto_cnt != 8'h00)
        begin
            s_d.auto_cnt = s_q.auto_cnt - 8'h01;
        end
        // Register nine and other addresses are taken and dropped here
        if (wr_bus.wr)
        begin
            if (wr_bus.addr <= `ADDR_GROUP_LAST)
            begin
                s_d.grp_div[wr_bus.addr[2:0]] = wr_bus.data[`GROUP_DIV_MSB:`GROUP_DIV_LSB];
            end
            else if (wr_bus.addr == `ADDR_FORMAT_A)
            begin
                s_d.fmt_a = wr_bus.data;
            end
            else if (wr_bus.addr == `ADDR_FORMAT_B)
            begin
                s_d.fmt_b = wr_bus.data;
            end
            else if (wr_bus.addr == `ADDR_FORMAT_C)
            begin
                s_d.fmt_c = wr_bus.data;
            end
            else if (wr_bus.addr == `ADDR_REF_CTRL)
            begin
                s_d.ref_ctrl = wr_bus.data;
            end
            else if (wr_bus.addr == `ADDR_SYNC_CTRL)
            begin
                s_d.sync_ctrl = wr_bus.data;
            end
            else if (wr_bus.addr == `ADDR_FEEDBACK_DIV)
            begin
                s_d.auto_cnt = 8'(`AUTO_SYNC_CYCLES);
            end
        end

        // Polarity is applied before the pin counts as asserted
        pin_sync = sync_pin_i ^ s_q.sync_ctrl[`SYNC_POL_BIT];
        sync_now = pin_sync | (s_q.auto_cnt != 8'h00);
        s_d.sync_on = sync_now;

        for (int g = 0; g < 6; g++)
        begin
            div_eff = (s_q.grp_div[g] == 11'h000) ? 11'h001 : s_q.grp_div[g];
            part = sync_now & ~s_q.sync_ctrl[`SYNC_EXCL_LSB + g];
            // Holding the counter at zero for the whole sync is what aligns the groups;
            // excluded groups keep their count, so old alignment survives
            if (part)
            begin
                s_d.grp_cnt[g] = 11'h000;
            end
            else if (vco_tick_i)
            begin
                if (s_q.grp_cnt[g] + 11'h001 >= div_eff)
                begin
                    s_d.grp_cnt[g] = 11'h000;
                end
                else
                begin
                    s_d.grp_cnt[g] = s_q.grp_cnt[g] + 11'h001;
                end
            end
            // One extra bit so a divider of 2047 does not wrap the half period to zero
            level = ~part & ({1'b0, s_q.grp_cnt[g]} < (({1'b0, div_eff} + 12'h001) >> 1));
            for (int k = 0; k < 2; k++)
            begin
                if (g < 2)
                begin
                    bank = s_q.fmt_a;
                end
                else if (g < 4)
                begin
                    bank = s_q.fmt_b;
                end
                else
                begin
                    bank = s_q.fmt_c;
                end
                fmt = bank[`FMT_LSB + 4 * ((2 * g + k) % 4) +: 4];
                pins = clock_output_pkg::fmt_pins(fmt, level);
                s_d.clk_p[2 * g + k] = pins[1];
                s_d.clk_n[2 * g + k] = pins[0];
            end
        end

        ref_a_src = s_q.ref_ctrl[`REF_A_SEL_BIT] ? ref_div : reference_input_i;
        ref_b_src = s_q.ref_ctrl[`REF_B_SEL_BIT] ? ref_div : reference_input_i;
        pins = clock_output_pkg::fmt_pins(s_q.ref_ctrl[`REF_A_FMT_MSB:`REF_A_FMT_LSB], ref_a_src);
        if (!s_q.ref_ctrl[`REF_A_EN_BIT])
        begin
            pins = 2'h0;
        end
        s_d.ref_a_p = pins[1];
        s_d.ref_a_n = pins[0];
        // Buffer B has no format choice: enabled means differential LVPECL
        s_d.ref_b_p = s_q.ref_ctrl[`REF_B_EN_BIT] & ref_b_src;
        s_d.ref_b_n = s_q.ref_ctrl[`REF_B_EN_BIT] & ~ref_b_src;
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
            s_q.fmt_a <= `REG_RESET;
            s_q.fmt_b <= `REG_RESET;
            s_q.fmt_c <= `REG_RESET;
            s_q.ref_ctrl <= `REG_RESET;
            s_q.sync_ctrl <= `REG_RESET;
            s_q.grp_div <= {6{`GROUP_DIV_RESET}};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    always_comb
    begin
        for (int g = 0; g < 6; g++)
        begin
            group_extended_mode_o[g] = (s_q.grp_div[g] >= `EXT_MODE_MIN);
        end
    end

    assign main_clock_output_p_o = s_q.clk_p;
    assign main_clock_output_n_o = s_q.clk_n;
    assign ref_buffer_a_p_o = s_q.ref_a_p;
    assign ref_buffer_a_n_o = s_q.ref_a_n;
    assign ref_buffer_b_p_o = s_q.ref_b_p;
    assign ref_buffer_b_n_o = s_q.ref_b_n;
    assign ref_buffer_b_amplitude_o = s_q.ref_ctrl[`REF_B_AMP_MSB:`REF_B_AMP_LSB];
    assign sync_active_o = s_q.sync_on;
endmodule

// File: hw/clock_output_pkg.sv
/*
 Types and the output format decode shared by the clock output modules.
 Assumes clock_output_cfg.svh is on the include path.
*/
`include "clock_output_cfg.svh"

package clock_output_pkg;

    typedef enum logic [3:0] {
        FMT_OFF = 4'h0, FMT_LVDS = 4'h1, FMT_PECL_0 = 4'h2, FMT_PECL_1 = 4'h3,
        FMT_PECL_2 = 4'h4, FMT_PECL_3 = 4'h5, FMT_NORM_INV = 4'h6, FMT_INV_NORM = 4'h7,
        FMT_NORM_NORM = 4'h8, FMT_INV_INV = 4'h9, FMT_LOW_NORM = 4'hA, FMT_LOW_INV = 4'hB,
        FMT_NORM_LOW = 4'hC, FMT_INV_LOW = 4'hD, FMT_LOW_LOW = 4'hE
    } main_output_format_t;

    typedef struct packed {
        logic [31:0] shift;
        logic sclk_prev;
        logic latch_prev;
        logic wr;
        logic [4:0] addr;
        logic [31:0] data;
    } serial_state_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic level;
    } ref_div_state_t;

    typedef struct packed {
        logic [31:0] fmt_a;
        logic [31:0] fmt_b;
        logic [31:0] fmt_c;
        logic [31:0] ref_ctrl;
        logic [31:0] sync_ctrl;
        logic [5:0][10:0] grp_div;
        logic [5:0][10:0] grp_cnt;
        logic [7:0] auto_cnt;
        logic ref_prev;
        logic [11:0] clk_p;
        logic [11:0] clk_n;
        logic ref_a_p;
        logic ref_a_n;
        logic ref_b_p;
        logic ref_b_n;
        logic sync_on;
    } top_state_t;

    // Pin pair {p, n} for one output from its format and source clock level
    function automatic logic [1:0] fmt_pins(input logic [3:0] fmt, input logic clk);
        logic [1:0] r;
        r = 2'h0;
        case (fmt)
            4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: r = {clk, ~clk};
            4'h7: r = {~clk, clk};
            4'h8: r = {clk, clk};
            4'h9: r = {~clk, ~clk};
            4'hA: r = {1'b0, clk};
            4'hB: r = {1'b0, ~clk};
            4'hC: r = {clk, 1'b0};
            4'hD: r = {~clk, 1'b0};
            default: r = 2'h0;
        endcase
        return r;
    endfunction

endpackage

// File: hw/ref_output_divider.sv
/*
 Shared reference output divider, counting reference rising edges.
 Assumes ref_edge_i is a one-cycle pulse per reference period. Odd ratios
 give a short high phase: a 50% duty would need the falling edge too.
*/
`timescale 1ns/100ps

module ref_output_divider (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ref_edge_i,
    input wire logic [2:0] code_i,
    output logic div_o
);
    clock_output_pkg::ref_div_state_t s_q, s_d;
    logic [3:0] ratio;

    always_comb
    begin
        // No code gives a ratio of one; that is the bypass path's job
        if (code_i == 3'h0)
        begin
            ratio = 4'h8;
        end
        else if (code_i == 3'h1)
        begin
            ratio = 4'h2;
        end
        else
        begin
            ratio = {1'b0, code_i};
        end
        s_d = s_q;
        if (ref_edge_i)
        begin
            if ({1'b0, s_q.cnt} + 4'h1 >= ratio)
            begin
                s_d.cnt = 3'h0;
            end
            else
            begin
                s_d.cnt = s_q.cnt + 3'h1;
            end
        end
        s_d.level = ({1'b0, s_d.cnt} < {1'b0, ratio[3:1]});
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign div_o = s_q.level;
endmodule

// File: hw/reg_write_if.sv
/*
 Register write strobe with its address and data word.
 Assumes one clock; the strobe is a one-cycle pulse.
*/
`timescale 1ns/100ps

interface reg_write_if;
    logic wr;
    logic [4:0] addr;
    logic [31:0] data;
    modport source (output wr, output addr, output data);
    modport sink (input wr, input addr, input data);
endinterface

// File: hw/serial_reg_port.sv
/*
 Serial register port: shifts 32 bits MSB first on serial clock rising
 edges; a latch rising edge presents the word, address in bits 4:0.
 Assumes pins already synchronous to clock_i and slower than it.
*/
`timescale 1ns/100ps

module serial_reg_port (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic reg_clk_i,
    input wire logic reg_data_i,
    input wire logic reg_latch_i,
    reg_write_if.source wr_o
);
    clock_output_pkg::serial_state_t s_q, s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.wr = 1'b0;
        s_d.sclk_prev = reg_clk_i;
        s_d.latch_prev = reg_latch_i;
        if (reg_clk_i && !s_q.sclk_prev)
        begin
            s_d.shift = {s_q.shift[30:0], reg_data_i};
        end
        if (reg_latch_i && !s_q.latch_prev)
        begin
            s_d.wr = 1'b1;
            s_d.addr = s_q.shift[4:0];
            s_d.data = s_q.shift;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign wr_o.wr = s_q.wr;
    assign wr_o.addr = s_q.addr;
    assign wr_o.data = s_q.data;
endmodule
